//--- design/port_alternate_function_override.sv
/*
  Port A alternate function override block with a Wishbone slave for
  the port registers, the pin-change mask and the digital-disable bits.
  Assumes pads are resolved outside from pad_out_o, pad_oe_o and
  pad_pullup_o, and that the sleep controller drives sleep_clamp_i.
*/
`timescale 1ns/1ns

// Behaviour
// - every pin gets its own override signals
// - pull-up overrides come from owning peripheral
// - pull-up override enable selects override value
// - otherwise pull-up needs dir 0, out 1, disable 0
// - direction override selects driver enable
// - driven level from value override or out bit
// - value override ignores out bit for the driven level
// - input-enable override beats processor state
// - override value keeps input alive in sleep
// - alternate input taken before the synchronizer
// - analog path wired straight to the pad
// - pin n feeds pin-change source n
// - pin n feeds analog converter channel n
// - global pull-up disable kills register pull-ups
// - sleep clamp grounds inputs unless overridden
module port_alternate_function_override (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [pin_mux_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [pin_mux_pkg::DAT_W-1:0] wb_dat_i,
  output logic [pin_mux_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sleep_clamp_i,
  input wire logic [pin_mux_pkg::PIN_CNT-1:0] pad_in_i,
  output logic [pin_mux_pkg::PIN_CNT-1:0] pad_out_o,
  output logic [pin_mux_pkg::PIN_CNT-1:0] pad_oe_o,
  output logic [pin_mux_pkg::PIN_CNT-1:0] pad_pullup_o,
  output logic [pin_mux_pkg::PIN_CNT-1:0] pad_input_en_o,
  output logic [pin_mux_pkg::PIN_CNT-1:0] pin_change_in_o,
  output logic [pin_mux_pkg::PIN_CNT-1:0] analog_pad_path_o
);

  // ==========================================================
  // declarations
  localparam int N = pin_mux_pkg::PIN_CNT;

  // port register bits
  logic [N-1:0] dir_bit_r;
  logic [N-1:0] out_bit_r;
  logic [N-1:0] out_bit_nxt;
  logic global_pullup_disable_r;

  // pin-change and analog control bits
  logic [N-1:0] pin_change_mask_bit_r;
  logic pin_change_group0_enable_r;
  logic [N-1:0] analog_digital_disable_bit_r;

  // per-pin override signals from the owning modules
  logic [N-1:0] pullup_override_en;
  logic [N-1:0] pullup_override_val;
  logic [N-1:0] dir_override_en;
  logic [N-1:0] dir_override_val;
  logic [N-1:0] out_value_override_en;
  logic [N-1:0] out_value_override_val;
  logic [N-1:0] input_en_override_en;
  logic [N-1:0] input_en_override_val;

  // per-pin cell results
  logic [N-1:0] pullup_en;
  logic [N-1:0] drive_en;
  logic [N-1:0] drive_val;
  logic [N-1:0] input_en;
  logic [N-1:0] alt_digital_in;

  // port synchronizer for the readable pin value
  logic [N-1:0] pin_meta_r;
  logic [N-1:0] pin_sync_r;

  // bus slave
  logic ack_r;
  logic [pin_mux_pkg::DAT_W-1:0] rd_nxt;
  logic [pin_mux_pkg::DAT_W-1:0] rd_r;
  logic bus_req;
  logic wr_go;
  logic lane0;
  logic [7:0] wr_byte;
  logic [7:0] reg_adr;

  // ==========================================================
  // bus request decode
  assign bus_req = wb_cyc_i && wb_stb_i;
  assign lane0 = wb_sel_i[pin_mux_pkg::BYTE_LANE0];
  assign wr_go = bus_req && wb_we_i && ack_r && lane0; // write lands at the ack edge
  assign wr_byte = wb_dat_i[7:0];
  assign reg_adr = {wb_adr_i[7:2], 2'h0};

  // ==========================================================
  // acknowledge: one cycle after the strobe, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'h0;
    end else begin
      ack_r <= bus_req && !ack_r;
    end
  end

  // ==========================================================
  // read data mux, unmapped offsets read as zero
  always_comb begin
    rd_nxt = pin_mux_pkg::WORD_ZERO;
    unique case (reg_adr)
      pin_mux_pkg::OFS_DIR: begin
        rd_nxt[7:0] = dir_bit_r;
      end
      pin_mux_pkg::OFS_OUT: begin
        rd_nxt[7:0] = out_bit_r;
      end
      pin_mux_pkg::OFS_PIN: begin
        rd_nxt[7:0] = pin_sync_r;
      end
      pin_mux_pkg::OFS_MCU_CTRL: begin
        rd_nxt[pin_mux_pkg::PULLUP_DIS_BIT] = global_pullup_disable_r;
      end
      pin_mux_pkg::OFS_PC_MASK: begin
        rd_nxt[7:0] = pin_change_mask_bit_r;
      end
      pin_mux_pkg::OFS_PC_CTRL: begin
        rd_nxt[pin_mux_pkg::GRP0_BIT] = pin_change_group0_enable_r;
      end
      pin_mux_pkg::OFS_ADC_DDIS: begin
        rd_nxt[7:0] = analog_digital_disable_bit_r;
      end
      pin_mux_pkg::OFS_STATUS: begin
        rd_nxt[pin_mux_pkg::ST_PU_LSB +: 8] = pad_pullup_o;
        rd_nxt[pin_mux_pkg::ST_DRV_LSB +: 8] = pad_oe_o;
        rd_nxt[pin_mux_pkg::ST_IEN_LSB +: 8] = pad_input_en_o;
        rd_nxt[pin_mux_pkg::ST_PIN_LSB +: 8] = pin_sync_r;
      end
      default: begin
        rd_nxt = pin_mux_pkg::WORD_ZERO;
      end
    endcase
  end

  // read data is captured with the ack and held while it stands
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_r <= pin_mux_pkg::WORD_ZERO;
    end else if (bus_req && !ack_r) begin
      rd_r <= rd_nxt;
    end
  end

  // ==========================================================
  // direction register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_bit_r <= pin_mux_pkg::DIR_RST;
    end else if (wr_go && reg_adr == pin_mux_pkg::OFS_DIR) begin
      dir_bit_r <= wr_byte;
    end
  end

  // ==========================================================
  // output register: direct write, or write ones to pin to toggle
  always_comb begin
    out_bit_nxt = out_bit_r;
    if (wr_go && reg_adr == pin_mux_pkg::OFS_OUT) begin
      out_bit_nxt = wr_byte;
    end else if (wr_go && reg_adr == pin_mux_pkg::OFS_PIN) begin
      out_bit_nxt = out_bit_r ^ wr_byte;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_bit_r <= pin_mux_pkg::OUT_RST;
    end else begin
      out_bit_r <= out_bit_nxt;
    end
  end

  // ==========================================================
  // control register: global pull-up disable, shared by all pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      global_pullup_disable_r <= pin_mux_pkg::PULLUP_DIS_RST;
    end else if (wr_go && reg_adr == pin_mux_pkg::OFS_MCU_CTRL) begin
      global_pullup_disable_r <= wr_byte[pin_mux_pkg::PULLUP_DIS_BIT];
    end
  end

  // ==========================================================
  // pin-change mask bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_change_mask_bit_r <= pin_mux_pkg::MASK_RST;
    end else if (wr_go && reg_adr == pin_mux_pkg::OFS_PC_MASK) begin
      pin_change_mask_bit_r <= wr_byte;
    end
  end

  // pin-change group 0 enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_change_group0_enable_r <= pin_mux_pkg::GRP0_RST;
    end else if (wr_go && reg_adr == pin_mux_pkg::OFS_PC_CTRL) begin
      pin_change_group0_enable_r <= wr_byte[pin_mux_pkg::GRP0_BIT];
    end
  end

  // ==========================================================
  // analog digital-disable bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      analog_digital_disable_bit_r <= pin_mux_pkg::DDIS_RST;
    end else if (wr_go && reg_adr == pin_mux_pkg::OFS_ADC_DDIS) begin
      analog_digital_disable_bit_r <= wr_byte;
    end
  end

  // ==========================================================
  // per-pin override generation and cells
  generate
    for (genvar i = 0; i < N; i++) begin : g_pin
      // analog converter channel owns no pull, dir or value override
      assign pullup_override_en[i] = 1'h0;
      assign pullup_override_val[i] = 1'h0;
      assign dir_override_en[i] = 1'h0;
      assign dir_override_val[i] = 1'h0;
      assign out_value_override_en[i] = 1'h0;
      assign out_value_override_val[i] = 1'h0;

      // pin-change source keeps the input on, analog disable turns it off
      assign input_en_override_val[i] =
        pin_change_mask_bit_r[i] && pin_change_group0_enable_r;
      assign input_en_override_en[i] =
        input_en_override_val[i] || analog_digital_disable_bit_r[i];

      // one cell per pin, no override signal is shared
      pin_override_cell u_cell (
        .dir_bit_i(dir_bit_r[i]),
        .out_bit_i(out_bit_r[i]),
        .global_pullup_disable_i(global_pullup_disable_r),
        .sleep_clamp_i(sleep_clamp_i),
        .pullup_override_en_i(pullup_override_en[i]),
        .pullup_override_val_i(pullup_override_val[i]),
        .dir_override_en_i(dir_override_en[i]),
        .dir_override_val_i(dir_override_val[i]),
        .out_value_override_en_i(out_value_override_en[i]),
        .out_value_override_val_i(out_value_override_val[i]),
        .input_en_override_en_i(input_en_override_en[i]),
        .input_en_override_val_i(input_en_override_val[i]),
        .pad_in_i(pad_in_i[i]),
        .pullup_en_o(pullup_en[i]),
        .drive_en_o(drive_en[i]),
        .drive_val_o(drive_val[i]),
        .input_en_o(input_en[i]),
        .alt_digital_in_o(alt_digital_in[i])
      );
    end
  endgenerate

  // ==========================================================
  // pad control outputs, registered; tri-stated while in reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_oe_o <= pin_mux_pkg::BYTE_ZERO;
      pad_out_o <= pin_mux_pkg::BYTE_ZERO;
    end else begin
      pad_oe_o <= drive_en;
      pad_out_o <= drive_val;
    end
  end

  // pull-up and input enable toward the pad
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_pullup_o <= pin_mux_pkg::BYTE_ZERO;
      pad_input_en_o <= pin_mux_pkg::BYTE_ZERO;
    end else begin
      pad_pullup_o <= pullup_en;
      pad_input_en_o <= input_en;
    end
  end

  // ==========================================================
  // port synchronizer for software reads of the pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta_r <= pin_mux_pkg::BYTE_ZERO;
      pin_sync_r <= pin_mux_pkg::BYTE_ZERO;
    end else begin
      pin_meta_r <= alt_digital_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  // ==========================================================
  // unsynchronized paths: pin-change sources and analog channels
  assign pin_change_in_o = alt_digital_in;
  assign analog_pad_path_o = pad_in_i;

  // bus outputs
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rd_r;

endmodule : port_alternate_function_override

//--- design/pin_mux_pkg.sv
/*
  Shared constants for the port A override multiplexer: register
  offsets, reset values and field positions.
  Assumes a 32-bit classic Wishbone bus with byte addresses.
*/
package pin_mux_pkg;

  // ==========================================================
  // geometry
  localparam int PIN_CNT = 8;
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_DIR = 8'h00;
  localparam logic [7:0] OFS_OUT = 8'h04;
  localparam logic [7:0] OFS_PIN = 8'h08;
  localparam logic [7:0] OFS_MCU_CTRL = 8'h0C;
  localparam logic [7:0] OFS_PC_MASK = 8'h10;
  localparam logic [7:0] OFS_PC_CTRL = 8'h14;
  localparam logic [7:0] OFS_ADC_DDIS = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;

  // ==========================================================
  // reset values
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [7:0] OUT_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] DDIS_RST = 8'h00;
  localparam logic PULLUP_DIS_RST = 1'h0;
  localparam logic GRP0_RST = 1'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h00000000;

  // ==========================================================
  // field positions
  localparam int PULLUP_DIS_BIT = 0;
  localparam int GRP0_BIT = 0;
  localparam int BYTE_LANE0 = 0;
  localparam int ST_PU_LSB = 0;
  localparam int ST_DRV_LSB = 8;
  localparam int ST_IEN_LSB = 16;
  localparam int ST_PIN_LSB = 24;

endpackage : pin_mux_pkg

//--- design/pin_override_cell.sv
/*
  One pin's override cell: merges the port register bits with the
  override enables and values of the owning peripheral.
  Assumes all inputs are synchronous levels; purely combinational.
*/
`timescale 1ns/1ns

module pin_override_cell (
  input wire logic dir_bit_i,
  input wire logic out_bit_i,
  input wire logic global_pullup_disable_i,
  input wire logic sleep_clamp_i,
  input wire logic pullup_override_en_i,
  input wire logic pullup_override_val_i,
  input wire logic dir_override_en_i,
  input wire logic dir_override_val_i,
  input wire logic out_value_override_en_i,
  input wire logic out_value_override_val_i,
  input wire logic input_en_override_en_i,
  input wire logic input_en_override_val_i,
  input wire logic pad_in_i,
  output logic pullup_en_o,
  output logic drive_en_o,
  output logic drive_val_o,
  output logic input_en_o,
  output logic alt_digital_in_o
);

  // ==========================================================
  // pull-up selection
  always_comb begin
    if (pullup_override_en_i) begin
      pullup_en_o = pullup_override_val_i;
    end else begin
      pullup_en_o = !dir_bit_i && out_bit_i && !global_pullup_disable_i;
    end
  end

  // ==========================================================
  // output driver enable and driven level
  assign drive_en_o = dir_override_en_i ? dir_override_val_i : dir_bit_i;
  assign drive_val_o = out_value_override_en_i ? out_value_override_val_i : out_bit_i;

  // ==========================================================
  // digital input enable, sleep clamp grounds the input otherwise
  assign input_en_o = input_en_override_en_i ? input_en_override_val_i : !sleep_clamp_i;

  // taken after the input buffer, before any synchronizer
  assign alt_digital_in_o = pad_in_i && input_en_o;

endmodule : pin_override_cell

//--- verification/pin_mux_checker.sv
/*
  Port relations of the port A override block.
  Assumes it is bound into port_alternate_function_override.
*/
`timescale 1ns/1ns

module pin_mux_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic sleep_clamp_i,
  input wire logic [7:0] pad_in_i,
  input wire logic [7:0] pad_out_o,
  input wire logic [7:0] pad_oe_o,
  input wire logic [7:0] pad_pullup_o,
  input wire logic [7:0] pad_input_en_o,
  input wire logic [7:0] pin_change_in_o,
  input wire logic [7:0] analog_pad_path_o
);
  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic wr_ack;
  // write acknowledge, the only cause of a register change
  assign wr_ack = wb_ack_o & wb_we_i;
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_prompt: assert property ($rose(wb_cyc_i & wb_stb_i) |=> wb_ack_o)
    else $error("ack not one cycle after request");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i & wb_stb_i))
    else $error("ack without request");
  a_analog_wire: assert property (analog_pad_path_o == pad_in_i)
    else $error("analog path differs from pad");
  a_pinchg_src: assert property ((pin_change_in_o & ~pad_in_i) == 8'h00)
    else $error("pin change input high on low pad");
  a_pullup_dir: assert property ((pad_pullup_o & pad_oe_o) == 8'h00)
    else $error("pull-up on a driven pin");
  a_reset_quiet: assert property ($fell(rst_i) |-> pad_oe_o == 8'h00 &&
    pad_pullup_o == 8'h00 && !wb_ack_o) else $error("pads not quiet after reset");
  a_pad_cause: assert property ($changed({pad_oe_o, pad_out_o, pad_pullup_o}) |->
    $past(wr_ack) || $past(wr_ack, 2) || $past(wr_ack, 3))
    else $error("pad control changed without a write");
  a_ien_cause: assert property ($changed(pad_input_en_o) |->
    $past(wr_ack) || $past(wr_ack, 2) || $past(wr_ack, 3) || $past(rst_i, 2) ||
    $past(rst_i, 3) || $past(sleep_clamp_i) != $past(sleep_clamp_i, 2) ||
    $past(sleep_clamp_i, 2) != $past(sleep_clamp_i, 3))
    else $error("input enable changed without cause");
endmodule : pin_mux_checker

bind port_alternate_function_override pin_mux_checker u_chk (.clk_i(clk_i),
  .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_ack_o(wb_ack_o), .sleep_clamp_i(sleep_clamp_i), .pad_in_i(pad_in_i),
  .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .pad_pullup_o(pad_pullup_o),
  .pad_input_en_o(pad_input_en_o), .pin_change_in_o(pin_change_in_o),
  .analog_pad_path_o(analog_pad_path_o));

//--- verification/pad_model.sv
/*
  Pad model: resolves each pin from the driver, an external source and the pull-up.
  Assumes external sources never fight an enabled driver.
*/
`timescale 1ns/1ns

module pad_model (
  input wire logic clk_i,
  input wire logic [7:0] pad_out_i,
  input wire logic [7:0] pad_oe_i,
  input wire logic [7:0] pad_pullup_i,
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_val_i,
  output logic [7:0] pad_lvl_o
);
  // ==========================================================
  // resolution
  logic [7:0] float_r = 8'h55;
  // a floating pin shows a pattern that changes every cycle
  always @(posedge clk_i) float_r <= ~float_r;
  // driver first, then external source, then pull-up
  assign pad_lvl_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_en_i & ext_val_i) |
    (~pad_oe_i & ~ext_en_i & (pad_pullup_i | float_r));
endmodule : pad_model

//--- verification/tb_top.sv
/*
  Self-checking bench of the override block over classic Wishbone.
  Assumes the register map and latencies of pin_mux_pkg and the hand-over.
*/
`timescale 1ns/1ns

module tb_top;
  // ==========================================================
  // signals and instances
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, sleep_clamp_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00, pad_in_i, pad_out_o, pad_oe_o, pad_pullup_o, pad_input_en_o;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000, wb_dat_o, rd, seed = 32'hD7AB;
  logic [7:0] pin_change_in_o, analog_pad_path_o, ext_en = 8'hFF, ext_val = 8'h00;
  logic [7:0] m_dir = 8'h00, m_out = 8'h00, m_mask = 8'h00, m_ddis = 8'h00;
  logic m_pull_dis = 1'b0, m_grp = 1'b0;
  int failures = 0, comparisons = 0;
  // free-running clock
  always #2 clk_i = ~clk_i;
  port_alternate_function_override u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sleep_clamp_i(sleep_clamp_i), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o),
    .pad_oe_o(pad_oe_o), .pad_pullup_o(pad_pullup_o), .pad_input_en_o(pad_input_en_o),
    .pin_change_in_o(pin_change_in_o), .analog_pad_path_o(analog_pad_path_o));
  pad_model u_pad (.clk_i(clk_i), .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o),
    .pad_pullup_i(pad_pullup_o), .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_lvl_o(pad_in_i));

  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic [7:0] exp_ien();
    return (m_mask & {8{m_grp}}) | (~((m_mask & {8{m_grp}}) | m_ddis) & {8{~sleep_clamp_i}});
  endfunction : exp_ien
  function automatic logic [7:0] exp_pu();
    return ~m_dir & m_out & {8{~m_pull_dis}};
  endfunction : exp_pu
  task automatic give_verdict();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  // one classic cycle; data taken at the ack edge, bounded wait
  task automatic wb_cycle(input logic we, input logic [7:0] a, input logic [7:0] d,
                          input logic [3:0] s);
    bit got;
    got = 1'b0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, 24'h000000, d, s};
    for (int i = 0; i < 20 && !got; i++) begin
      @(posedge clk_i);
      got = (wb_ack_o === 1'b1);
      if (got) rd = wb_dat_o;
    end
    // released at the ack edge itself, after the slave has sampled it
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    if (!got) begin
      failures++;
      give_verdict();
    end
  endtask : wb_cycle
  task automatic set_all();
    wb_cycle(1'b1, pin_mux_pkg::OFS_DIR, m_dir, 4'hF);
    wb_cycle(1'b1, pin_mux_pkg::OFS_OUT, m_out, 4'hF);
    wb_cycle(1'b1, pin_mux_pkg::OFS_MCU_CTRL, {7'h00, m_pull_dis}, 4'hF);
    wb_cycle(1'b1, pin_mux_pkg::OFS_PC_MASK, m_mask, 4'hF);
    wb_cycle(1'b1, pin_mux_pkg::OFS_PC_CTRL, {7'h00, m_grp}, 4'hF);
    wb_cycle(1'b1, pin_mux_pkg::OFS_ADC_DDIS, m_ddis, 4'hF);
  endtask : set_all
  // compare pads and status against the model once settled
  task automatic verify();
    logic [7:0] ie, pu, lv;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    ie = exp_ien();
    pu = exp_pu();
    lv = (m_dir & m_out) | (~m_dir & ((ext_en & ext_val) | (~ext_en & pu)));
    check("oe", m_dir, pad_oe_o);
    check("out", m_dir & m_out, pad_oe_o & pad_out_o);
    check("out_lvl", m_out, pad_out_o);
    check("pullup", pu, pad_pullup_o);
    check("input_en", ie, pad_input_en_o);
    check("pin_change", lv & ie, pin_change_in_o);
    check("analog", lv, analog_pad_path_o);
    wb_cycle(1'b0, pin_mux_pkg::OFS_STATUS, 8'h00, 4'hF);
    check("st_pu", pu, rd[7:0]);
    check("st_oe", m_dir, rd[15:8]);
    check("st_ien", ie, rd[23:16]);
    check("st_pin", lv & ie, rd[31:24]);
  endtask : verify

  // ==========================================================
  // main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    verify();
    // unmapped place and a write without byte lane 0 leave registers alone
    wb_cycle(1'b1, 8'h20, 8'hFF, 4'hF);
    wb_cycle(1'b0, 8'h20, 8'h00, 4'hF);
    check("unmapped", 8'h00, rd[7:0]);
    wb_cycle(1'b1, pin_mux_pkg::OFS_DIR, 8'hFF, 4'hE);
    wb_cycle(1'b0, pin_mux_pkg::OFS_DIR, 8'h00, 4'hF);
    check("dir_sel", 8'h00, rd[7:0]);
    // pull-ups alone hold undriven pins high
    m_out = 8'hFF;
    ext_en <= 8'h00;
    set_all();
    verify();
    wb_cycle(1'b1, pin_mux_pkg::OFS_PIN, 8'h0F, 4'hF);
    m_out = m_out ^ 8'h0F;
    ext_en <= 8'hFF;
    wb_cycle(1'b0, pin_mux_pkg::OFS_OUT, 8'h00, 4'hF);
    check("toggle", m_out, rd[7:0]);
    // sleep with mask and group enable keeps inputs alive
    {m_mask, m_grp, m_ddis} = {8'h0F, 1'b1, 8'hF0};
    sleep_clamp_i <= 1'b1;
    set_all();
    verify();
    for (int n = 0; n < 40; n++) begin
      repeat (32) seed = lfsr(seed);
      {m_dir, m_out, m_mask, m_ddis} = seed;
      repeat (32) seed = lfsr(seed);
      {m_pull_dis, m_grp} = seed[1:0];
      ext_val <= seed[15:8];
      sleep_clamp_i <= seed[2];
      set_all();
      verify();
    end
    give_verdict();
  end
endmodule : tb_top
